// file: dv/dual_port_gpio_asserts.sv
// Checker: bus answer, pin drive and interrupt taps of the port block.
// Assumes ce_i high over bus transfers and pins steady over a read.
`timescale 1ns/1ps
module gpio_chk (
  input wire logic clk_i, rst_b_i, ce_i, cyc_i, stb_i, we_i, ack_o,
  input wire logic [5:0] adr_i,
  input wire logic [3:0] sel_i, edge_irq_input_o,
  input wire logic [31:0] dat_i, dat_o,
  input wire gpio_pkg::power_mode_t power_mode_i,
  input wire logic [7:0] port_zero_pin_i, port_zero_pin_o, port_zero_pin_oe_o,
  input wire logic [7:0] port_one_pin_i, level_irq_input_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire tk = cyc_i & stb_i & ce_i & !ack_o;
  wire wr = tk & we_i & sel_i[0];
  wire [3:0] ix = adr_i[5:2];
  a_ack_pulse: assert property (tk |=> ack_o ##1 !ack_o)
    else $error("ack not a single pulse");
  a_dir_to_oe: assert property (wr && ix == 4'h1 && !power_mode_i[1]
    |=> port_zero_pin_oe_o == $past(dat_i[7:0])) else $error("oe not direction");
  a_data_to_out: assert property (wr && ix == 4'h0
    |=> port_zero_pin_o == $past(dat_i[7:0])) else $error("latch not written");
  a_oe_hold: assert property (!tk && $stable(power_mode_i)
    |=> $stable(port_zero_pin_oe_o)) else $error("oe moved unasked");
  a_level_tap: assert property ($past(rst_b_i && ce_i)
    |-> level_irq_input_o == $past(port_zero_pin_i)) else $error("level tap wrong");
  a_edge_tap: assert property ($past(rst_b_i && ce_i)
    |-> edge_irq_input_o == $past(port_one_pin_i[3:0])) else $error("edge tap wrong");
  a_read_pins: assert property (tk && !we_i && ix == 4'h0 && $stable(port_zero_pin_i)
    |=> dat_o[7:0] == $past(port_zero_pin_i)) else $error("read not pins");
  a_dir_unread: assert property (tk && !we_i && ix == 4'h1
    |=> dat_o == 32'h0) else $error("direction readable");
endmodule
bind dual_port_gpio gpio_chk gpio_chk_i(.*);

// file: dv/gpio_board.sv
// Board side of one port: resolves each pin from block and board drive.
// Assumes the bench sets board levels; undriven pins have no pull.
`timescale 1ns/1ps
module gpio_board (
  input wire logic clk_i,
  input wire logic bd_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] out_i,
  input wire logic [7:0] ext_i,
  output logic [7:0] pin_o
);
  logic [7:0] last_reg;
  always_ff @(posedge clk_i) last_reg <= pin_o;
  // Floating pins invert each cycle so a stale level never reads as valid
  always_comb pin_o = (oe_i & out_i) | (~oe_i & (bd_i ? ext_i : ~last_reg));
endmodule

// file: dv/testbench.sv
// Bench: Wishbone register calls and board levels against the port block.
// Assumes ack within a few cycles and two board models on the pins.
`timescale 1ns/1ps
module testbench;
  logic clk_i = 0, rst_b_i = 0, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, bd = 1, ce = 1;
  logic [5:0] adr_i = 6'h00;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic [7:0] e0 = 8'h3c, e1 = 8'h96, p0, p1, o0, o1, oe0, oe1, lv, q;
  logic [3:0] eg;
  gpio_pkg::power_mode_t md = gpio_pkg::PWR_RUN;
  int fails = 0, n_checks = 0;
  always #5 clk_i = ~clk_i;
  dual_port_gpio dual_port_gpio_i(.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'h1), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .power_mode_i(md), .port_zero_pin_i(p0), .port_zero_pin_o(o0),
    .port_zero_pin_oe_o(oe0), .port_one_pin_i(p1), .port_one_pin_o(o1),
    .port_one_pin_oe_o(oe1), .level_irq_input_o(lv), .edge_irq_input_o(eg));
  gpio_board gpio_board_i(.clk_i(clk_i), .bd_i(bd), .oe_i(oe0), .out_i(o0), .ext_i(e0), .pin_o(p0));
  gpio_board gpio_board_one_i(.clk_i(clk_i), .bd_i(bd), .oe_i(oe1), .out_i(o1), .ext_i(e1),
    .pin_o(p1));
  task automatic bus(input logic w, input logic [3:0] ix, input logic [7:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {ix, 2'b00};
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 9);
    if (ack_o !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: no ack", $time);
    end
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    cmp(oe0 | oe1, 8'h00);
    bus(1'b1, 4'h0, 8'ha5);
    cmp(o0, 8'ha5);
    bus(1'b0, 4'h0, 8'h00);
    cmp(q, 8'h3c);
    bus(1'b1, 4'h1, 8'hf0);
    cmp(oe0, 8'hf0);
    bus(1'b0, 4'h0, 8'h00);
    cmp(q, 8'hac);
    bus(1'b0, 4'h1, 8'h00);
    cmp(q, 8'h00);
    bus(1'b0, 4'h7, 8'h00);
    cmp(q, 8'h00);
    $display("port zero test done");
    bus(1'b1, 4'h5, 8'h07);
    cmp(o0, 8'h25);
    bus(1'b1, 4'h2, 8'h00);
    bus(1'b1, 4'h3, 8'hff);
    bus(1'b1, 4'h5, 8'h1a);
    cmp(o1, 8'h04);
    bus(1'b0, 4'h2, 8'h00);
    cmp(q, 8'h04);
    cmp({4'h0, eg}, 8'h04);
    $display("bit op test done");
    bus(1'b1, 4'h4, 8'h01);
    for (int m = 0; m < 4; m++) begin
      md <= gpio_pkg::power_mode_t'(m);
      e0 <= 8'h0f ^ 8'(m);
      repeat (3) @(posedge clk_i);
      cmp(oe0, m > 1 ? 8'h00 : 8'hf0);
      cmp(lv, (m > 1 ? 8'h00 : 8'h20) | (8'h0f ^ 8'(m)));
    end
    bus(1'b1, 4'h4, 8'h00);
    cmp(oe0, 8'hf0);
    $display("standby test done");
    ce <= 1'b0;
    e0 <= 8'h55;
    repeat (3) @(posedge clk_i);
    cmp(lv, 8'h2c);
    ce <= 1'b1;
    repeat (3) @(posedge clk_i);
    cmp(lv, 8'h25);
    $display("clock enable test done");
    rst_b_i <= 1'b0;
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    cmp(oe0 | oe1, 8'h00);
    cmp(o0, 8'h25);
    cmp(o1, 8'h04);
    $display("reset test done");
    close_out();
  end
  initial begin
    #20000;
    fails++;
    close_out();
  end
endmodule

// file: src/dual_port_gpio.sv
// Two eight-bit bidirectional ports with Wishbone registers and interrupt taps.
// Assumes pins and power mode are synchronous to clk_i; pad resolves oe/out.
`timescale 1ns/1ps
module dual_port_gpio (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [gpio_pkg::ADDR_WIDTH+1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire gpio_pkg::power_mode_t power_mode_i,
  input wire logic [gpio_pkg::PORT_WIDTH-1:0] port_zero_pin_i,
  output logic [gpio_pkg::PORT_WIDTH-1:0] port_zero_pin_o,
  output logic [gpio_pkg::PORT_WIDTH-1:0] port_zero_pin_oe_o,
  input wire logic [gpio_pkg::PORT_WIDTH-1:0] port_one_pin_i,
  output logic [gpio_pkg::PORT_WIDTH-1:0] port_one_pin_o,
  output logic [gpio_pkg::PORT_WIDTH-1:0] port_one_pin_oe_o,
  output logic [gpio_pkg::PORT_WIDTH-1:0] level_irq_input_o,
  output logic [gpio_pkg::EDGE_IRQ_PINS-1:0] edge_irq_input_o
);
  gpio_pkg::gpio_state_t state_reg;
  gpio_pkg::gpio_state_t state_next;
  gpio_pkg::latch_pair_t latch_reg;
  gpio_pkg::latch_pair_t latch_next;
  logic [gpio_pkg::ADDR_WIDTH-1:0] idx;
  logic req;
  logic forced_off;
  logic [gpio_pkg::PORT_WIDTH-1:0] bit_mask;
  logic [gpio_pkg::BITOP_NUM_WIDTH-1:0] bit_num;

  function automatic gpio_pkg::pin_drive_t drive(
    input logic [gpio_pkg::PORT_WIDTH-1:0] latch,
    input logic [gpio_pkg::PORT_WIDTH-1:0] dir,
    input logic off
  );
    gpio_pkg::pin_drive_t d;
    d.out = latch;
    d.oe = off ? '0 : dir;
    return d;
  endfunction

  assign idx = adr_i[gpio_pkg::ADDR_WIDTH+1:2];
  assign req = cyc_i && stb_i && !state_reg.ack;
  assign bit_num = dat_i[gpio_pkg::BITOP_NUM_LSB +: gpio_pkg::BITOP_NUM_WIDTH];
  assign bit_mask = gpio_pkg::PORT_WIDTH'(1) << bit_num;

  always_comb begin
    state_next = state_reg;
    latch_next = latch_reg;
    forced_off = 1'b0;
    // Pins sampled once; read path never sees interrupt enables
    state_next.zero_pin = port_zero_pin_i;
    state_next.one_pin = port_one_pin_i;
    state_next.ack = req;
    state_next.rdata = gpio_pkg::UNMAPPED_READ;
    if (req && we_i && sel_i[0]) begin
      unique case (idx)
        gpio_pkg::IDX_PORT_ZERO_DATA: latch_next.zero = dat_i[7:0];
        gpio_pkg::IDX_PORT_ONE_DATA: latch_next.one = dat_i[7:0];
        gpio_pkg::IDX_PORT_ZERO_DIR: state_next.zero_dir = dat_i[7:0];
        gpio_pkg::IDX_PORT_ONE_DIR: state_next.one_dir = dat_i[7:0];
        gpio_pkg::IDX_STANDBY_CTRL: state_next.float_sel = dat_i[gpio_pkg::STANDBY_FLOAT_BIT];
        gpio_pkg::IDX_BIT_OP: begin
          // Untouched bits come from the latch, never from the pins
          if (dat_i[gpio_pkg::BITOP_PORT_BIT]) begin
            latch_next.one = dat_i[gpio_pkg::BITOP_SET_BIT] ?
              (latch_reg.one | bit_mask) : (latch_reg.one & ~bit_mask);
          end else begin
            latch_next.zero = dat_i[gpio_pkg::BITOP_SET_BIT] ?
              (latch_reg.zero | bit_mask) : (latch_reg.zero & ~bit_mask);
          end
        end
        default: ;
      endcase
    end
    if (req && !we_i) begin
      unique case (idx)
        gpio_pkg::IDX_PORT_ZERO_DATA: state_next.rdata = {24'h000000, state_reg.zero_pin};
        gpio_pkg::IDX_PORT_ONE_DATA: state_next.rdata = {24'h000000, state_reg.one_pin};
        gpio_pkg::IDX_STANDBY_CTRL: state_next.rdata = {31'h00000000, state_reg.float_sel};
        default: state_next.rdata = gpio_pkg::UNMAPPED_READ;
      endcase
    end
    // Sleep and run keep normal drive; float bit zero too
    forced_off = state_next.float_sel &&
      (power_mode_i == gpio_pkg::PWR_STOP || power_mode_i == gpio_pkg::PWR_WATCH);
    state_next.zero_drive = drive(latch_next.zero, state_next.zero_dir, forced_off);
    state_next.one_drive = drive(latch_next.one, state_next.one_dir, forced_off);
    // Interrupt taps stay live while pins float
    state_next.level_irq = port_zero_pin_i;
    state_next.edge_irq = port_one_pin_i[gpio_pkg::EDGE_IRQ_PINS-1:0];
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= '0;
      state_reg.zero_dir <= gpio_pkg::DIR_RESET;
      state_reg.one_dir <= gpio_pkg::DIR_RESET;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  // No reset: latches keep their contents; load them before setting direction
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      latch_reg <= latch_next;
    end
  end

  assign dat_o = state_reg.rdata;
  assign ack_o = state_reg.ack;
  assign port_zero_pin_o = state_reg.zero_drive.out;
  assign port_zero_pin_oe_o = state_reg.zero_drive.oe;
  assign port_one_pin_o = state_reg.one_drive.out;
  assign port_one_pin_oe_o = state_reg.one_drive.oe;
  assign level_irq_input_o = state_reg.level_irq;
  assign edge_irq_input_o = state_reg.edge_irq;
endmodule

// file: src/gpio_pkg.sv
// Constants and carrier types for the dual eight-bit general-purpose port block.
// Assumes a classic Wishbone slave with 32-bit data and one clock domain.
package gpio_pkg;
  localparam int unsigned PORT_WIDTH = 8;
  localparam int unsigned ADDR_WIDTH = 4;
  // Printed offsets are register indexes; byte address is four times index
  localparam logic [ADDR_WIDTH-1:0] IDX_PORT_ZERO_DATA = 4'h0;
  localparam logic [ADDR_WIDTH-1:0] IDX_PORT_ZERO_DIR = 4'h1;
  localparam logic [ADDR_WIDTH-1:0] IDX_PORT_ONE_DATA = 4'h2;
  localparam logic [ADDR_WIDTH-1:0] IDX_PORT_ONE_DIR = 4'h3;
  localparam logic [ADDR_WIDTH-1:0] IDX_STANDBY_CTRL = 4'h4;
  localparam logic [ADDR_WIDTH-1:0] IDX_BIT_OP = 4'h5;
  localparam int unsigned STANDBY_FLOAT_BIT = 0;
  localparam int unsigned BITOP_NUM_LSB = 0;
  localparam int unsigned BITOP_NUM_WIDTH = 3;
  localparam int unsigned BITOP_PORT_BIT = 3;
  localparam int unsigned BITOP_SET_BIT = 4;
  localparam int unsigned EDGE_IRQ_PINS = 4;
  localparam logic [PORT_WIDTH-1:0] DIR_RESET = 8'h00;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_SLEEP = 2'b01,
    PWR_STOP = 2'b10,
    PWR_WATCH = 2'b11
  } power_mode_t;

  typedef struct packed {
    logic [PORT_WIDTH-1:0] out;
    logic [PORT_WIDTH-1:0] oe;
  } pin_drive_t;

  // Output latches live apart from the reset state: reset must not touch them
  typedef struct packed {
    logic [PORT_WIDTH-1:0] zero;
    logic [PORT_WIDTH-1:0] one;
  } latch_pair_t;

  typedef struct packed {
    logic [PORT_WIDTH-1:0] zero_dir;
    logic [PORT_WIDTH-1:0] one_dir;
    logic float_sel;
    logic [PORT_WIDTH-1:0] zero_pin;
    logic [PORT_WIDTH-1:0] one_pin;
    pin_drive_t zero_drive;
    pin_drive_t one_drive;
    logic [PORT_WIDTH-1:0] level_irq;
    logic [EDGE_IRQ_PINS-1:0] edge_irq;
    logic ack;
    logic [31:0] rdata;
  } gpio_state_t;
endpackage
